// >>> verilog/ifsc_defs.svh
// Overview of operation
// R01 - input overvoltage fault limit word, reset D3A0h
// R02 - limits and times are two-byte linear words
// R03 - policy bits 7:6 select fault action
// R04 - fault flags stick until clear-faults command
// R05 - retry field zero keeps output off
// R06 - retry fields 1..6 give that many restarts
// R07 - retry field seven restarts without fault check
// R08 - low three bits give delay and retry spacing
// R09 - both fault policies reset to 80h
// R10 - warnings set other, input, warning bits; notify
// R11 - undervoltage fault clears above warning limit
// R12 - warning limits reset D34Dh and CA30h
// R13 - undervoltage fault limit word, reset CA00h
// R14 - power good above threshold, off below UV limit
// R15 - power good threshold resets to 0.9 strap voltage
// R16 - turn-on delay before rise, reset CA80h
// R17 - rise lasts turn-on ramp time, reset D280h
// R18 - turn-off delay before fall
// R19 - fall lasts turn-off ramp time
// R20 - linear word: 5-bit exponent, 11-bit mantissa
`ifndef IFSC_DEFS_SVH
`define IFSC_DEFS_SVH
// command codes
`define IFSC_CMD_VIN_OV_FLT    8'h55
`define IFSC_CMD_VIN_OV_POL    8'h56
`define IFSC_CMD_VIN_OV_WARN   8'h57
`define IFSC_CMD_VIN_UV_WARN   8'h58
`define IFSC_CMD_VIN_UV_FLT    8'h59
`define IFSC_CMD_VIN_UV_POL    8'h5A
`define IFSC_CMD_PGOOD_ON      8'h5E
`define IFSC_CMD_TON_DLY       8'h60
`define IFSC_CMD_TON_RAMP      8'h61
`define IFSC_CMD_TOFF_DLY      8'h64
`define IFSC_CMD_TOFF_RAMP     8'h65
`define IFSC_CMD_CLEAR_FAULTS  8'h03
`define IFSC_CMD_STATUS_WORD   8'h79
`define IFSC_CMD_STATUS_INPUT  8'h7C
// reset values
`define IFSC_RST_VIN_OV_FLT    16'hD3A0
`define IFSC_RST_POLICY        8'h80
`define IFSC_RST_VIN_OV_WARN   16'hD34D
`define IFSC_RST_VIN_UV_WARN   16'hCA30
`define IFSC_RST_VIN_UV_FLT    16'hCA00
`define IFSC_RST_TON_DLY       16'hCA80
`define IFSC_RST_TON_RAMP      16'hD280
`define IFSC_RST_TOFF_DLY      16'hCA80
`define IFSC_RST_TOFF_RAMP     16'hD280
// policy fields
`define IFSC_POL_ACT_HI        7
`define IFSC_POL_ACT_LO        6
`define IFSC_POL_RTY_HI        5
`define IFSC_POL_RTY_LO        3
`define IFSC_POL_TIM_HI        2
`define IFSC_POL_TIM_LO        0
// status word / status input bit positions
`define IFSC_SW_INPUT          13
`define IFSC_SW_PGOOD_N        11
`define IFSC_SW_OFF            6
`define IFSC_SW_VIN_UV         3
`define IFSC_SW_NOTA           0
`define IFSC_SI_OV_FLT         7
`define IFSC_SI_OV_WARN        6
`define IFSC_SI_UV_WARN        5
`define IFSC_SI_UV_FLT         4
// timing: one ms of core_clk at 200 MHz, default one retry unit (ms)
`define IFSC_CLK_MHZ           200
`define IFSC_MS_CYCLES         (`IFSC_CLK_MHZ * 1000)
`define IFSC_FLT_UNIT_MS       1
`endif

// >>> verilog/ifsc_pkg.sv
package ifsc_pkg;
  // fault action selected by policy bits 7:6
  typedef enum logic [1:0] {
    ACT_IGNORE,
    ACT_DLY_RETRY,
    ACT_RETRY,
    ACT_HOLDOFF
  } ifsc_act_e;
  // output sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_ON_DLY,
    SEQ_RISE,
    SEQ_ON,
    SEQ_OFF_DLY,
    SEQ_FALL,
    SEQ_FLT_DLY,
    SEQ_RETRY_WAIT
  } ifsc_seq_e;
endpackage

// >>> verilog/ifsc_lin_ticks.sv
`timescale 1ns/1ps
// converts a linear word (ms units) into core_clk cycles
module ifsc_lin_ticks #(
  parameter int MS_CYCLES = 200000
) (
  // linear value in
  input  wire logic [15:0] lin_word,
  // cycle count out, negative values clamped to zero
  output logic      [39:0] cycles
);
  logic signed [4:0]  exp_v;   // signed exponent
  logic signed [10:0] man_v;   // signed mantissa
  logic        [39:0] base;    // mantissa in cycles
  always_comb begin
    exp_v = lin_word[15:11]; // R20
    man_v = lin_word[10:0];  // R20
    // negative times are meaningless here, so they clamp to zero
    base  = man_v[10] ? 40'h00_0000_0000 : 40'(man_v) * 40'(MS_CYCLES);
    if (exp_v[4]) begin
      cycles = base >> 6'(-exp_v); // R20
    end else begin
      // positive exponents kept small so the product stays in range
      cycles = base << 6'(exp_v[2:0]); // R20
    end
  end
endmodule // ifsc_lin_ticks

// >>> verilog/ifsc_core.sv
`timescale 1ns/1ps
`include "ifsc_defs.svh"
// register bank, input fault policy and output sequencer
module ifsc_core #(
  parameter int        MS_CYCLES   = `IFSC_MS_CYCLES,
  parameter int        UNIT_CYCLES = `IFSC_FLT_UNIT_MS * `IFSC_MS_CYCLES,
  parameter logic [15:0] PG_DEFAULT = 16'h0000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // command port from the bus engine
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  // pin-strap output setpoint, linear unsigned
  input  wire logic [15:0] strap_vout,
  // monitored levels, same encoding as the limits
  input  wire logic [15:0] vin_level,
  input  wire logic [15:0] vout_level,
  input  wire logic [15:0] vout_uv_limit,
  // enable request
  input  wire logic        run_req,
  // outputs
  output logic             out_enable,
  output logic             ramp_up,
  output logic             ramp_down,
  output logic             power_good,
  output logic             host_alert
);
  typedef struct packed {
    logic [15:0] ov_flt;
    logic [7:0]  ov_pol;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_flt;
    logic [7:0]  uv_pol;
    logic [15:0] pg_on;
    logic [15:0] ton_dly;
    logic [15:0] ton_ramp;
    logic [15:0] toff_dly;
    logic [15:0] toff_ramp;
    logic [3:0]  sin;        // ov flt, ov warn, uv warn, uv flt
    logic        uv_active;  // latched undervoltage
    logic        pg;
    logic        strap_done;
    ifsc_pkg::ifsc_seq_e seq;
    logic [39:0] cnt;
    logic [2:0]  tries;
    logic        use_ov;     // which policy owns the fault
    logic        alert;
    logic [15:0] rdata;
  } ifsc_state_s;
  ifsc_state_s st_reg;  // registered state
  ifsc_state_s st_next; // next state
  // decoded times
  logic [39:0] t_on_dly;
  logic [39:0] t_on_ramp;
  logic [39:0] t_off_dly;
  logic [39:0] t_off_ramp;
  ifsc_lin_ticks #(.MS_CYCLES(MS_CYCLES)) u_ton_d (
    .lin_word(st_reg.ton_dly), .cycles(t_on_dly));
  ifsc_lin_ticks #(.MS_CYCLES(MS_CYCLES)) u_ton_r (
    .lin_word(st_reg.ton_ramp), .cycles(t_on_ramp));
  ifsc_lin_ticks #(.MS_CYCLES(MS_CYCLES)) u_tof_d (
    .lin_word(st_reg.toff_dly), .cycles(t_off_dly));
  ifsc_lin_ticks #(.MS_CYCLES(MS_CYCLES)) u_tof_r (
    .lin_word(st_reg.toff_ramp), .cycles(t_off_ramp));
  // comparisons; limits are compared as raw words, same scaling assumed
  logic ov_fault;
  logic ov_warn;
  logic uv_warn;
  logic uv_trip;
  logic uv_fault;
  logic fault_now;
  logic sel_ov;      // policy owner for this cycle
  logic [7:0] pol;
  logic [1:0] act;
  logic [2:0] rty;
  logic [39:0] flt_time;
  always_comb begin
    ov_fault  = vin_level > st_reg.ov_flt;
    ov_warn   = vin_level > st_reg.ov_warn;
    uv_warn   = vin_level < st_reg.uv_warn;
    uv_trip   = vin_level < st_reg.uv_flt;
    // hysteresis: held until the input rises above the warning limit
    uv_fault  = uv_trip | (st_reg.uv_active & uv_warn); // R11
    fault_now = ov_fault | uv_fault;
    // a fault acting now picks its own policy at once; the stored owner
    // would still name the previous fault on the first cycle
    sel_ov    = st_reg.use_ov;
    if (uv_fault && st_reg.uv_pol[`IFSC_POL_ACT_HI:`IFSC_POL_ACT_LO] != 2'b00) begin
      sel_ov = 1'b0;
    end
    if (ov_fault && st_reg.ov_pol[`IFSC_POL_ACT_HI:`IFSC_POL_ACT_LO] != 2'b00) begin
      sel_ov = 1'b1;
    end
    pol       = sel_ov ? st_reg.ov_pol : st_reg.uv_pol;
    act       = pol[`IFSC_POL_ACT_HI:`IFSC_POL_ACT_LO]; // R03
    rty       = pol[`IFSC_POL_RTY_HI:`IFSC_POL_RTY_LO];
    // count times one unit; unit is UNIT_CYCLES whatever the fault type, same for both inputs
    flt_time  = 40'(pol[`IFSC_POL_TIM_HI:`IFSC_POL_TIM_LO]) * 40'(UNIT_CYCLES); // R08
  end
  // next-state logic: registers, flags, sequencer
  always_comb begin
    logic [3:0] set_bits;
    logic       new_flt;
    set_bits = 4'h0;
    new_flt  = 1'b0;
    st_next  = st_reg;
    // strap caught once after reset release
    if (!st_reg.strap_done) begin
      st_next.pg_on      = 16'((32'(strap_vout) * 32'd9) / 32'd10); // R15
      st_next.strap_done = 1'b1;
    end
    // host writes, word or byte per command
    if (cmd_write) begin
      case (cmd_code)
        `IFSC_CMD_VIN_OV_FLT:  st_next.ov_flt = cmd_wdata; // R01 R02
        `IFSC_CMD_VIN_OV_POL:  st_next.ov_pol = cmd_wdata[7:0];
        `IFSC_CMD_VIN_OV_WARN: st_next.ov_warn = cmd_wdata;
        `IFSC_CMD_VIN_UV_WARN: st_next.uv_warn = cmd_wdata;
        `IFSC_CMD_VIN_UV_FLT:  st_next.uv_flt = cmd_wdata; // R13
        `IFSC_CMD_VIN_UV_POL:  st_next.uv_pol = cmd_wdata[7:0];
        `IFSC_CMD_PGOOD_ON:    st_next.pg_on = cmd_wdata;
        `IFSC_CMD_TON_DLY:     st_next.ton_dly = cmd_wdata;
        `IFSC_CMD_TON_RAMP:    st_next.ton_ramp = cmd_wdata;
        `IFSC_CMD_TOFF_DLY:    st_next.toff_dly = cmd_wdata;
        `IFSC_CMD_TOFF_RAMP:   st_next.toff_ramp = cmd_wdata;
        `IFSC_CMD_CLEAR_FAULTS: begin
          st_next.sin   = 4'h0; // R04
          st_next.alert = 1'b0;
        end
        default: ;
      endcase
    end
    // host reads, answer registered next cycle
    if (cmd_read) begin
      case (cmd_code)
        `IFSC_CMD_VIN_OV_FLT:  st_next.rdata = st_reg.ov_flt;
        `IFSC_CMD_VIN_OV_POL:  st_next.rdata = {8'h00, st_reg.ov_pol};
        `IFSC_CMD_VIN_OV_WARN: st_next.rdata = st_reg.ov_warn;
        `IFSC_CMD_VIN_UV_WARN: st_next.rdata = st_reg.uv_warn;
        `IFSC_CMD_VIN_UV_FLT:  st_next.rdata = st_reg.uv_flt;
        `IFSC_CMD_VIN_UV_POL:  st_next.rdata = {8'h00, st_reg.uv_pol};
        `IFSC_CMD_PGOOD_ON:    st_next.rdata = st_reg.pg_on;
        `IFSC_CMD_TON_DLY:     st_next.rdata = st_reg.ton_dly;
        `IFSC_CMD_TON_RAMP:    st_next.rdata = st_reg.ton_ramp;
        `IFSC_CMD_TOFF_DLY:    st_next.rdata = st_reg.toff_dly;
        `IFSC_CMD_TOFF_RAMP:   st_next.rdata = st_reg.toff_ramp;
        `IFSC_CMD_STATUS_INPUT: st_next.rdata = {8'h00, st_reg.sin, 4'h0};
        `IFSC_CMD_STATUS_WORD: begin
          st_next.rdata = 16'h0000;
          st_next.rdata[`IFSC_SW_INPUT]   = |st_reg.sin;
          st_next.rdata[`IFSC_SW_PGOOD_N] = ~st_reg.pg;
          st_next.rdata[`IFSC_SW_OFF]     = ~out_enable;
          st_next.rdata[`IFSC_SW_VIN_UV]  = st_reg.sin[0];
          st_next.rdata[`IFSC_SW_NOTA]    = st_reg.sin[2] | st_reg.sin[1]; // R10
        end
        default: st_next.rdata = 16'h0000;
      endcase
    end
    // sticky input flags; a new event beats a same-cycle clear
    set_bits = {ov_fault, ov_warn, uv_warn, uv_fault};
    if (ov_fault && st_reg.ov_pol[7:6] == 2'b00) begin
      set_bits[3] = 1'b1; // R04 ignore still flags
    end
    // compare against the flags after a clear, so a clear cannot swallow an alert
    if (|(set_bits & ~st_next.sin)) begin
      st_next.alert = 1'b1; // R10
    end
    st_next.sin = st_next.sin | set_bits; // R04 R10
    st_next.uv_active = uv_fault; // R11
    // power good with hysteresis between threshold and UV limit
    if (vout_level > st_reg.pg_on && st_reg.seq == ifsc_pkg::SEQ_ON) begin
      st_next.pg = 1'b1; // R14
    end else if (vout_level < vout_uv_limit || !out_enable) begin
      st_next.pg = 1'b0; // R14
    end
    // which fault takes action this cycle
    if (ov_fault && st_reg.ov_pol[7:6] != 2'b00) begin
      new_flt        = 1'b1;
      st_next.use_ov = 1'b1;
    end else if (uv_fault && st_reg.uv_pol[7:6] != 2'b00) begin
      new_flt        = 1'b1;
      st_next.use_ov = 1'b0;
    end
    // output sequencer
    st_next.cnt = (st_reg.cnt == 40'h00_0000_0000) ? st_reg.cnt : st_reg.cnt - 40'h00_0000_0001;
    case (st_reg.seq)
      ifsc_pkg::SEQ_OFF: begin
        if (run_req && !new_flt) begin
          st_next.seq   = ifsc_pkg::SEQ_ON_DLY;
          st_next.cnt   = t_on_dly; // R16
          st_next.tries = 3'h0;
        end
      end
      ifsc_pkg::SEQ_ON_DLY, ifsc_pkg::SEQ_RISE, ifsc_pkg::SEQ_ON: begin
        if (new_flt) begin
          st_next.seq = ifsc_pkg::SEQ_FLT_DLY;
          // delay-disable waits the count; others act at once
          st_next.cnt = (act == 2'b01) ? flt_time : 40'h00_0000_0000; // R03 R08
        end else if (!run_req) begin
          st_next.seq = ifsc_pkg::SEQ_OFF_DLY;
          st_next.cnt = t_off_dly; // R18
        end else if (st_reg.seq == ifsc_pkg::SEQ_ON_DLY && st_reg.cnt == 40'h00_0000_0000) begin
          st_next.seq = ifsc_pkg::SEQ_RISE;
          st_next.cnt = t_on_ramp; // R17
        end else if (st_reg.seq == ifsc_pkg::SEQ_RISE && st_reg.cnt == 40'h00_0000_0000) begin
          st_next.seq   = ifsc_pkg::SEQ_ON;
          // a start that reaches full output ends the retry series
          st_next.tries = 3'h0; // R06
        end
      end
      ifsc_pkg::SEQ_OFF_DLY: begin
        if (st_reg.cnt == 40'h00_0000_0000) begin
          st_next.seq = ifsc_pkg::SEQ_FALL;
          st_next.cnt = t_off_ramp; // R19
        end
      end
      ifsc_pkg::SEQ_FALL: begin
        if (st_reg.cnt == 40'h00_0000_0000) begin
          st_next.seq = ifsc_pkg::SEQ_OFF; // R19
        end
      end
      ifsc_pkg::SEQ_FLT_DLY: begin
        // fault gone during the delay: keep running
        if (act == 2'b01 && !fault_now && st_reg.cnt != 40'h00_0000_0000) begin
          st_next.seq = ifsc_pkg::SEQ_ON;
        end else if (st_reg.cnt == 40'h00_0000_0000) begin
          st_next.seq = ifsc_pkg::SEQ_RETRY_WAIT;
          st_next.cnt = flt_time; // R06
        end
      end
      ifsc_pkg::SEQ_RETRY_WAIT: begin
        if (!run_req) begin
          st_next.seq = ifsc_pkg::SEQ_OFF;
        end else if (act == 2'b11) begin
          if (!fault_now) begin
            st_next.seq = ifsc_pkg::SEQ_ON_DLY; // R03 hold-off ends
            st_next.cnt = t_on_dly;
          end
        end else if (rty == 3'b000) begin
          st_next.seq = ifsc_pkg::SEQ_RETRY_WAIT; // R05 latched off
        end else if (st_reg.cnt == 40'h00_0000_0000) begin
          if (rty == 3'b111) begin
            st_next.seq = ifsc_pkg::SEQ_ON_DLY; // R07 no fault check
            st_next.cnt = t_on_dly;
          end else if (st_reg.tries < rty && !fault_now) begin
            st_next.seq   = ifsc_pkg::SEQ_ON_DLY; // R06
            st_next.cnt   = t_on_dly;
            st_next.tries = st_reg.tries + 3'h1;
          end else if (st_reg.tries < rty) begin
            st_next.cnt   = flt_time;
            st_next.tries = st_reg.tries + 3'h1; // R06 attempt used
          end
        end
      end
      default: st_next.seq = ifsc_pkg::SEQ_OFF;
    endcase
  end
  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg            <= '0;
      st_reg.ov_flt     <= `IFSC_RST_VIN_OV_FLT;   // R01
      st_reg.ov_pol     <= `IFSC_RST_POLICY;       // R09
      st_reg.ov_warn    <= `IFSC_RST_VIN_OV_WARN;  // R12
      st_reg.uv_warn    <= `IFSC_RST_VIN_UV_WARN;  // R12
      st_reg.uv_flt     <= `IFSC_RST_VIN_UV_FLT;   // R13
      st_reg.uv_pol     <= `IFSC_RST_POLICY;       // R09
      st_reg.pg_on      <= PG_DEFAULT;
      st_reg.ton_dly    <= `IFSC_RST_TON_DLY;      // R16
      st_reg.ton_ramp   <= `IFSC_RST_TON_RAMP;     // R17
      st_reg.toff_dly   <= `IFSC_RST_TOFF_DLY;
      st_reg.toff_ramp  <= `IFSC_RST_TOFF_RAMP;
      st_reg.seq        <= ifsc_pkg::SEQ_OFF;
    end else begin
      st_reg <= st_next;
    end
  end
  // outputs
  always_comb begin
    out_enable = st_reg.seq == ifsc_pkg::SEQ_RISE || st_reg.seq == ifsc_pkg::SEQ_ON ||
                 st_reg.seq == ifsc_pkg::SEQ_OFF_DLY || st_reg.seq == ifsc_pkg::SEQ_FALL ||
                 st_reg.seq == ifsc_pkg::SEQ_FLT_DLY;
    ramp_up    = st_reg.seq == ifsc_pkg::SEQ_RISE;
    ramp_down  = st_reg.seq == ifsc_pkg::SEQ_FALL;
    power_good = st_reg.pg;
    host_alert = st_reg.alert;
    cmd_rdata  = st_reg.rdata;
  end
  // checks
  chk_clear_wins_not: assert property (@(posedge core_clk) disable iff (reset) // R04
    (cmd_write && cmd_code == `IFSC_CMD_CLEAR_FAULTS && !ov_warn && !ov_fault && !uv_warn
     && !uv_fault) |=> st_reg.sin == 4'h0)
    else $error("flags not cleared");
  chk_warn_sets_flag: assert property (@(posedge core_clk) disable iff (reset) // R10
    ov_warn |=> st_reg.sin[2] && st_reg.alert)
    else $error("warning not flagged");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (reset) // R04
    (st_reg.sin[1] && !(cmd_write && cmd_code == `IFSC_CMD_CLEAR_FAULTS)) |=> st_reg.sin[1])
    else $error("flag dropped");
  chk_no_retry_off: assert property (@(posedge core_clk) disable iff (reset) // R05
    (st_reg.seq == ifsc_pkg::SEQ_RETRY_WAIT && act != 2'b11 && rty == 3'b000 && run_req)
    |=> st_reg.seq == ifsc_pkg::SEQ_RETRY_WAIT)
    else $error("restarted with no retry");
  chk_rise_after_dly: assert property (@(posedge core_clk) disable iff (reset) // R16
    (st_reg.seq == ifsc_pkg::SEQ_ON_DLY && st_reg.cnt != 40'h00_0000_0000)
    |=> st_reg.seq != ifsc_pkg::SEQ_RISE)
    else $error("rise before delay");
  chk_fall_after_dly: assert property (@(posedge core_clk) disable iff (reset) // R18
    $rose(st_reg.seq == ifsc_pkg::SEQ_FALL) |-> $past(st_reg.seq) == ifsc_pkg::SEQ_OFF_DLY)
    else $error("fall without delay");
  chk_pg_drops: assert property (@(posedge core_clk) disable iff (reset) // R14
    (vout_level < vout_uv_limit && !(vout_level > st_reg.pg_on)) |=> !power_good)
    else $error("power good held");
  chk_uv_hyst: assert property (@(posedge core_clk) disable iff (reset) // R11
    (st_reg.uv_active && uv_warn) |=> st_reg.uv_active && st_reg.sin[0])
    else $error("uv released early");
  chk_tries_bound: assert property (@(posedge core_clk) disable iff (reset) // R06
    (rty != 3'b111 && st_reg.seq == ifsc_pkg::SEQ_RETRY_WAIT) |-> st_reg.tries <= rty)
    else $error("too many retries");
endmodule // ifsc_core

// >>> testbench/ifsc_host_model.sv
`timescale 1ns/1ps
// host side of the command port; requests launch at the falling edge
module ifsc_host_model (
  // clock
  input  wire logic        core_clk,
  // command port
  output logic      [7:0]  cmd_code,
  output logic             cmd_write,
  output logic             cmd_read,
  output logic      [15:0] cmd_wdata,
  input  wire logic [15:0] cmd_rdata
);
  int gap;  // idle cycles after each request, lets the host be slow
  // idle lines at time zero
  initial begin
    gap       = 0;
    cmd_code  = 8'h00;
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // one write, strobe seen by exactly one rising edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge core_clk);
    cmd_code  = code;
    cmd_wdata = data;
    cmd_write = 1'b1;
    @(negedge core_clk);
    cmd_write = 1'b0;
    // released lines show no stale value
    cmd_wdata = ~data;
    repeat (gap) @(negedge core_clk);
  endtask
  // one read; data is registered at the read edge, taken half a cycle later
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(negedge core_clk);
    cmd_code = code;
    cmd_read = 1'b1;
    @(negedge core_clk);
    data     = cmd_rdata;
    cmd_read = 1'b0;
    cmd_code = ~code;
    repeat (gap) @(negedge core_clk);
  endtask
endmodule // ifsc_host_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the input fault and sequencing block
module tb_top;
  // clock, reset and design ports
  logic        core_clk;
  logic        reset;
  logic [7:0]  cmd_code;
  logic        cmd_write;
  logic        cmd_read;
  logic [15:0] cmd_wdata;
  logic [15:0] cmd_rdata;
  logic [15:0] strap_vout;
  logic [15:0] vin_level;
  logic [15:0] vout_level;
  logic [15:0] vout_uv_limit;
  logic        run_req;
  logic        out_enable;
  logic        ramp_up;
  logic        ramp_down;
  logic        power_good;
  logic        host_alert;
  // bookkeeping
  int          bad_count;
  int          total_checks;
  int          seed;
  int          n;
  logic [15:0] d;
  logic [15:0] w;
  logic        prev_en;
  logic [7:0]  codes [11] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h60, 8'h61,
                              8'h64, 8'h65, 8'h5e};
  logic [15:0] rstv  [10] = '{16'hd3a0, 16'h0080, 16'hd34d, 16'hca30, 16'hca00, 16'h0080,
                              16'hca80, 16'hd280, 16'hca80, 16'hd280};

  // short ms scale keeps the sequencer counts small: 1 ms = 10 cycles, unit 4
  ifsc_core #(.MS_CYCLES(10), .UNIT_CYCLES(4)) dut (
    .core_clk(core_clk), .reset(reset), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .strap_vout(strap_vout), .vin_level(vin_level), .vout_level(vout_level),
    .vout_uv_limit(vout_uv_limit), .run_req(run_req), .out_enable(out_enable),
    .ramp_up(ramp_up), .ramp_down(ramp_down), .power_good(power_good),
    .host_alert(host_alert));
  ifsc_host_model host (
    .core_clk(core_clk), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // verdict, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare a design value exactly
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare a measured cycle count against a window
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // pick an observed output by number
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = ramp_up;
      1: pick = ramp_down;
      2: pick = out_enable;
      default: pick = power_good;
    endcase
  endfunction
  // bounded wait for an output level; cnt is the cycles it took
  task automatic wait_sig(input int sel, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (pick(sel) !== val && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask
  // read one code and compare
  task automatic rd_chk(input string what, input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(code, v);
    check16(what, exp, v);
  endtask
  // step the input level and let the monitors settle
  task automatic vin_step(input logic [15:0] lvl, input int cyc);
    @(negedge core_clk);
    vin_level = lvl;
    repeat (cyc) @(negedge core_clk);
  endtask

  // watchdog: the whole sequence needs a little over a thousand cycles
  initial begin
    repeat (20000) @(negedge core_clk);
    bad_count++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end

  // main sequence
  initial begin
    bad_count = 0;
    total_checks = 0;
    seed = 32'hb97a;
    reset = 1'b1;
    strap_vout = 16'($random(seed));
    vin_level = 16'hcf00;
    vout_level = 16'h0000;
    vout_uv_limit = 16'h1000;
    run_req = 1'b0;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    // reset values, strap-derived threshold, unmapped code
    for (int i = 0; i < 10; i++) rd_chk("reset value", codes[i], rstv[i]);
    rd_chk("good threshold", 8'h5e, 16'((32'(strap_vout) * 9) / 10));
    rd_chk("unmapped", 8'h5b, 16'h0000);
    $display("done reset values");
    // random word and byte traffic, slow host half the time
    for (int i = 0; i < 12; i++) begin
      n = $unsigned($random(seed)) % 10;
      host.gap = i % 2;
      w = 16'($random(seed));
      host.wr(codes[n], w);
      rd_chk("readback", codes[n], (n == 1 || n == 5) ? {8'h00, w[7:0]} : w);
      host.wr(codes[n], rstv[n]);
    end
    host.gap = 0;
    host.wr(8'h03, 16'h0000);
    $display("done random access");
    // turn-on: 4 ms delay = 40 cycles, 2 ms rise = 20 cycles
    host.wr(8'h60, 16'h0004);
    host.wr(8'h61, 16'h0002);
    host.wr(8'h64, 16'h0003);
    host.wr(8'h65, 16'h0001);
    run_req = 1'b1;
    wait_sig(0, 1'b1, 200, n);
    check_rng("turn-on delay", 38, 43, n);
    wait_sig(0, 1'b0, 200, n);
    check_rng("rise time", 18, 22, n);
    check16("output on", 16'h0001, {15'h0000, out_enable});
    $display("done turn-on");
    // power good with hysteresis down to the uv limit
    host.wr(8'h5e, 16'h2000);
    vout_level = 16'h3000;
    wait_sig(3, 1'b1, 6, n);
    check_rng("good rise", 0, 5, n);
    vout_level = 16'h1800;
    repeat (6) @(negedge core_clk);
    check16("good held", 16'h0001, {15'h0000, power_good});
    vout_level = 16'h0800;
    wait_sig(3, 1'b0, 6, n);
    check_rng("good fall", 0, 5, n);
    host.wr(8'h03, 16'h0000);
    rd_chk("status cleared", 8'h7c, 16'h0000);
    $display("done power good");
    // overvoltage warning: sticky flags and alert
    vin_step(16'hd350, 4);
    rd_chk("warn flag", 8'h7c, 16'h0040);
    host.rd(8'h79, d);
    check16("warn summary", 16'h2001, d & 16'h2001);
    vin_step(16'hcf00, 4);
    rd_chk("warn sticky", 8'h7c, 16'h0040);
    check16("alert", 16'h0001, {15'h0000, host_alert});
    host.wr(8'h03, 16'h0000);
    vin_step(16'hcf00, 2);
    check16("alert clear", 16'h0000, {15'h0000, host_alert});
    $display("done warning");
    // ignore policy: flag set, output keeps running
    host.wr(8'h56, 16'h0000);
    vin_step(16'hd400, 12);
    check16("ignore runs", 16'h0001, {15'h0000, out_enable});
    rd_chk("ov flag", 8'h7c, 16'h00c0);
    vin_step(16'hcf00, 2);
    host.wr(8'h03, 16'h0000);
    // delay, disable, no retry: 7 units of 4 cycles
    host.wr(8'h56, 16'h0047);
    vin_step(16'hd400, 0);
    wait_sig(2, 1'b0, 100, n);
    check_rng("fault delay", 26, 32, n);
    vin_step(16'hcf00, 60);
    check16("no retry", 16'h0000, {15'h0000, out_enable});
    // restart, then turn-off: 3 ms delay, 1 ms fall
    run_req = 1'b0;
    repeat (5) @(negedge core_clk);
    run_req = 1'b1;
    wait_sig(0, 1'b1, 200, n);
    wait_sig(0, 1'b0, 200, n);
    host.wr(8'h03, 16'h0000);
    run_req = 1'b0;
    wait_sig(1, 1'b1, 200, n);
    check_rng("turn-off delay", 28, 33, n);
    wait_sig(1, 1'b0, 200, n);
    check_rng("fall time", 8, 12, n);
    run_req = 1'b1;
    wait_sig(0, 1'b1, 200, n);
    wait_sig(0, 1'b0, 200, n);
    $display("done delayed disable");
    // disable and one retry after the fault has gone
    host.wr(8'h56, 16'h0089);
    vin_step(16'hd400, 4);
    check16("retry off", 16'h0000, {15'h0000, out_enable});
    vin_step(16'hcf00, 0);
    wait_sig(2, 1'b1, 150, n);
    check_rng("retry restart", 0, 149, n);
    host.wr(8'h03, 16'h0000);
    // endless retry while the fault stays: several restarts
    host.wr(8'h56, 16'h00b9);
    vin_step(16'hd400, 0);
    n = 0;
    prev_en = out_enable;
    for (int i = 0; i < 500; i++) begin
      @(negedge core_clk);
      if (out_enable === 1'b1 && prev_en !== 1'b1) n++;
      prev_en = out_enable;
    end
    check_rng("endless restarts", 2, 500, n);
    vin_step(16'hcf00, 0);
    wait_sig(0, 1'b0, 200, n);
    wait_sig(0, 1'b1, 200, n);
    wait_sig(0, 1'b0, 200, n);
    host.wr(8'h03, 16'h0000);
    $display("done retry");
    // hold-off on undervoltage, cleared only above the warning limit
    host.wr(8'h5a, 16'h00c0);
    vin_step(16'hc900, 0);
    wait_sig(2, 1'b0, 8, n);
    check_rng("uv off", 0, 7, n);
    vin_step(16'hca10, 80);
    check16("uv hysteresis", 16'h0000, {15'h0000, out_enable});
    vin_step(16'hcf00, 0);
    wait_sig(2, 1'b1, 100, n);
    check_rng("uv resume", 0, 99, n);
    rd_chk("uv flag", 8'h7c, 16'h0030);
    host.rd(8'h79, d);
    check16("uv summary", 16'h2008, d & 16'h2008);
    $display("done hold-off");
    close_out();
  end
endmodule // tb_top
